/* File: rtl/ext_bus_wait_ctrl.sv */
/*
 * per-area external bus timing and bus release control with an
 * axi4-lite register port. assumes one clock, synchronous pins, and a
 * cpu side that holds access_req until access_done.
 */
// Design decision made here: the AXI4-Lite register port.
// Operation
// - one wait mode shared by all areas
// - disabled, pin-only and counted areas coexist
// - two-state areas: two states, no waits
// - mode 0: three states plus pin waits
// - count one, no pin wait: four states
// - mode 1: programmed waits then pin waits
// - access state register, one bit per area
// - wait enable register, one bit per area
// - sleep still grants external bus requests
// - standby ignores external bus requests
// - dma burst or block holds request
// - no grant while waits are inserted
// - word on byte area: two cycles
// - on-chip ram: sixteen bits, two states
// - internal io: three states always
`timescale 1ns/10ps
module ext_bus_wait_ctrl
	import ext_bus_wait_pkg::*;
#(
	parameter int area_count = 8
)
(
	input wire logic mclk,
	input wire logic reset_n,
	// axi4-lite slave
	input wire logic [addr_width-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [addr_width-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// cpu access side
	input wire logic access_req,
	input wire logic [2:0] access_area,
	input wire logic [1:0] access_kind,
	input wire logic access_word,
	output logic access_done,
	output logic ext_cycle_active,
	output logic access_byte_lane,
	output logic wide_bus,
	// external pins
	input wire logic wait_pin_n,
	input wire logic bus_request_in_n,
	output logic bus_grant_n,
	// direct_memory_access_unit burst or block transfer in progress
	input wire logic dma_burst_active
);
	logic rst_meta, rst_n;
	logic [area_count-1:0] access_state_select, next_ass;
	logic [area_count-1:0] wait_enable_per_area, next_wen;
	logic [area_count-1:0] bus_width_16, next_bw;
	logic [7:0] wait_count_control, next_wcc;
	logic [2:0] mode_control, next_mc;
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [addr_width-1:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic pending, next_pending;

	// -----------------------------------------------------------------
	// reset release
	// -----------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// decode shared by write and read paths
	function automatic logic addr_known(input logic [addr_width-1:0] a);
		return a == wait_enable_per_area_addr ||
			a == wait_count_control_addr ||
			a == access_state_select_addr ||
			a == mode_control_addr || a == bus_status_addr;
	endfunction : addr_known

	// -----------------------------------------------------------------
	// axi4-lite register port
	// -----------------------------------------------------------------
	// address and data latched separately, either order; one write
	// at a time so the ready lines fall while a response waits
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_ass = access_state_select;
		next_wen = wait_enable_per_area;
		next_bw = bus_width_16;
		next_wcc = wait_count_control;
		next_mc = mode_control;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_held && w_held && !s_axi_bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = addr_known(aw_addr) ? axi_okay : axi_slverr;
			if (w_strb[0]) begin
				unique case (aw_addr)
					access_state_select_addr:
						next_ass = w_data[area_count-1:0];
					wait_enable_per_area_addr: begin
						next_wen = w_data[area_count-1:0];
					end
					wait_count_control_addr:
						next_wcc = w_data[7:0];
					mode_control_addr: next_mc = w_data[2:0];
					default: ;
				endcase
			end
			// per-area bus width in byte 1 of the enable word
			if (w_strb[1] && aw_addr == wait_enable_per_area_addr) begin
				next_bw = w_data[8 +: area_count];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= axi_okay;
			access_state_select <= access_state_select_rst;
			wait_enable_per_area <= wait_enable_per_area_rst;
			bus_width_16 <= '1;
			wait_count_control <= wait_count_control_rst;
			mode_control <= mode_control_rst;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			access_state_select <= next_ass;
			wait_enable_per_area <= next_wen;
			bus_width_16 <= next_bw;
			wait_count_control <= next_wcc;
			mode_control <= next_mc;
		end
	end

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// read answers one cycle after the address is taken
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = addr_known(s_axi_araddr) ? axi_okay : axi_slverr;
			next_rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				access_state_select_addr:
					next_rdata[area_count-1:0] = access_state_select;
				wait_enable_per_area_addr: begin
					next_rdata[area_count-1:0] = wait_enable_per_area;
					next_rdata[8 +: area_count] = bus_width_16;
				end
				wait_count_control_addr: next_rdata[7:0] = wait_count_control;
				mode_control_addr: next_rdata[2:0] = mode_control;
				bus_status_addr:
					next_rdata[3:0] = {pending, ext_cycle_active,
						~bus_grant_n, access_done};
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= axi_okay;
		end else begin
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// -----------------------------------------------------------------
	// access sequencing
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {a_idle, a_first, a_second, a_released}
		astate_t;
	astate_t astate, next_astate;
	logic t_start, t_done;
	logic [3:0] base_states;
	logic [1:0] prog_waits;
	logic pin_allowed;
	logic next_access_done, next_ext_active, next_lane, next_wide;
	logic next_grant_n;
	logic three_state, wait_on, pin_mode1;

	assign three_state = access_state_select[access_area];
	assign wait_on = wait_enable_per_area[access_area];
	assign pin_mode1 = wait_count_control[wc_mode_lsb];

	// timing per kind: ram and io ignore the area settings
	always_comb begin
		base_states = states_three;
		prog_waits = 2'h0;
		pin_allowed = 1'b0;
		unique case (access_kind)
			kind_onchip_ram: base_states = states_two;
			kind_internal_io: base_states = states_three;
			default: begin
				if (!three_state) begin
					base_states = states_two;
				end else begin
					pin_allowed = 1'b1;
					// disabled areas and mode 0 take pin waits only
					if (wait_on && pin_mode1) begin
						prog_waits =
							wait_count_control[wc_count_lsb +: 2];
					end
				end
			end
		endcase
	end

	// count 1 adds a state, pin waits follow the pin
	bus_access_timer u_timer (
		.mclk(mclk),
		.rst_n(rst_n),
		.start(t_start),
		.base_states(base_states),
		.prog_waits(prog_waits),
		.pin_wait_allowed(pin_allowed),
		.wait_pin(!wait_pin_n),
		.busy(),
		.inserting_wait(),
		.done(t_done)
	);

	// word on a byte-wide external area splits into two cycles
	always_comb begin
		next_astate = astate;
		next_access_done = 1'b0;
		next_ext_active = ext_cycle_active;
		next_lane = access_byte_lane;
		next_wide = wide_bus;
		next_grant_n = bus_grant_n;
		next_pending = !bus_request_in_n && !mode_control[mc_standby_bit];
		t_start = 1'b0;
		unique case (astate)
			a_idle: begin
				if (pending && mode_control[mc_release_en_bit] &&
					!dma_burst_active) begin
					next_astate = a_released;
					next_grant_n = 1'b0;
				end else if (access_req && !access_done &&
					!mode_control[mc_sleep_bit]) begin
					t_start = 1'b1;
					next_astate = a_first;
					next_ext_active = (access_kind == kind_external);
					next_lane = 1'b0;
					next_wide = (access_kind == kind_onchip_ram) ||
						bus_width_16[access_area];
				end
			end
			a_first: begin
				if (t_done) begin
					if (access_word && !wide_bus) begin
						next_astate = a_second;
						next_lane = 1'b1;
						t_start = 1'b1; // no idle state between bytes
					end else begin
						next_astate = a_idle;
						next_access_done = 1'b1;
						next_ext_active = 1'b0;
					end
				end
			end
			a_second: begin
				if (t_done) begin
					next_astate = a_idle;
					next_access_done = 1'b1;
					next_ext_active = 1'b0;
				end
			end
			a_released: begin
				// master keeps request until done; standby ends nothing
				if (bus_request_in_n) begin
					next_astate = a_idle;
					next_grant_n = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			astate <= a_idle;
			access_done <= 1'b0;
			ext_cycle_active <= 1'b0;
			access_byte_lane <= 1'b0;
			wide_bus <= 1'b0;
			bus_grant_n <= 1'b1;
			pending <= 1'b0;
		end else begin
			astate <= next_astate;
			access_done <= next_access_done;
			ext_cycle_active <= next_ext_active;
			access_byte_lane <= next_lane;
			wide_bus <= next_wide;
			bus_grant_n <= next_grant_n;
			pending <= next_pending;
		end
	end
endmodule : ext_bus_wait_ctrl

/* File: rtl/ext_bus_wait_pkg.sv */
/*
 * constants for the external bus wait-state and bus release block.
 * assumes a single 200 MHz clock and an axi4-lite register port.
 */
package ext_bus_wait_pkg;
	// -----------------------------------------------------------------
	// register map (byte addresses)
	// -----------------------------------------------------------------
	// some printed offsets are not a multiple of four, so index * 4
	localparam logic [7:0] wait_enable_per_area_idx = 8'h38;
	localparam logic [7:0] wait_count_control_idx = 8'hF9;
	localparam logic [7:0] access_state_select_idx = 8'hFC;
	localparam logic [7:0] mode_control_idx = 8'h40;
	localparam logic [7:0] bus_status_idx = 8'h41;
	localparam logic [9:0] wait_enable_per_area_addr =
		{wait_enable_per_area_idx, 2'b00};
	localparam logic [9:0] wait_count_control_addr =
		{wait_count_control_idx, 2'b00};
	localparam logic [9:0] access_state_select_addr =
		{access_state_select_idx, 2'b00};
	localparam logic [9:0] mode_control_addr = {mode_control_idx, 2'b00};
	localparam logic [9:0] bus_status_addr = {bus_status_idx, 2'b00};
	localparam int addr_width = 10;

	// -----------------------------------------------------------------
	// reset values and fields
	// -----------------------------------------------------------------
	localparam logic [7:0] access_state_select_rst = 8'hFF;
	localparam logic [7:0] wait_enable_per_area_rst = 8'hFF;
	localparam logic [7:0] wait_count_control_rst = 8'hF3;
	// wait_count_control: [1:0] programmed count, [3:2] pin wait mode
	localparam int wc_count_lsb = 0;
	localparam int wc_mode_lsb = 2;
	// mode_control: bit0 ext bus release enable, bit1 sleep,
	// bit2 standby (hardware or software)
	localparam int mc_release_en_bit = 0;
	localparam int mc_sleep_bit = 1;
	localparam int mc_standby_bit = 2;
	localparam logic [2:0] mode_control_rst = 3'h0;

	// -----------------------------------------------------------------
	// access timing
	// -----------------------------------------------------------------
	localparam logic [3:0] states_two = 4'h2;
	localparam logic [3:0] states_three = 4'h3;
	localparam logic [1:0] axi_okay = 2'h0;
	localparam logic [1:0] axi_slverr = 2'h2;

	// access kinds presented by the cpu side
	typedef enum logic [1:0] {
		kind_external,
		kind_onchip_ram,
		kind_internal_io
	} access_kind_t;
endpackage : ext_bus_wait_pkg

/* File: rtl/bus_access_timer.sv */
/*
 * one external bus cycle timer: counts base states, then programmed
 * waits, then pin waits. assumes the caller holds the settings stable
 * while busy and that wait_pin is synchronous to mclk.
 */
`timescale 1ns/10ps
module bus_access_timer
	import ext_bus_wait_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [3:0] base_states,
	input wire logic [1:0] prog_waits,
	input wire logic pin_wait_allowed,
	input wire logic wait_pin,
	output logic busy,
	output logic inserting_wait,
	output logic done
);
	typedef enum logic [1:0] {t_idle, t_base, t_prog, t_pin} tstate_t;

	tstate_t state, next_state;
	logic [3:0] count, next_count;
	logic [1:0] prog, next_prog;
	logic pin_ok, next_pin_ok;
	logic next_done;

	// -----------------------------------------------------------------
	// state sequencing
	// -----------------------------------------------------------------
	// base states are counted down; pin sampled in the last base state, or in the last programmed wait when there is one
	always_comb begin
		next_state = state;
		next_count = count;
		next_prog = prog;
		next_pin_ok = pin_ok;
		next_done = 1'b0;
		unique case (state)
			t_idle: begin
				if (start) begin
					next_state = t_base;
					next_count = base_states - 4'h1;
					next_prog = prog_waits;
					next_pin_ok = pin_wait_allowed;
				end
			end
			t_base: begin
				if (count > 4'h1) begin
					next_count = count - 4'h1;
				end else if (prog != 2'h0) begin
					next_state = t_prog;
				end else if (pin_ok && wait_pin) begin
					next_state = t_pin;
				end else begin
					next_state = t_idle;
					next_done = 1'b1;
				end
			end
			t_prog: begin
				// programmed waits first, pin waits added afterwards
				if (prog > 2'h1) begin
					next_prog = prog - 2'h1;
				end else if (pin_ok && wait_pin) begin
					next_state = t_pin;
				end else begin
					next_state = t_idle;
					next_done = 1'b1;
				end
			end
			t_pin: begin
				if (!wait_pin) begin
					next_state = t_idle;
					next_done = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= t_idle;
			count <= 4'h0;
			prog <= 2'h0;
			pin_ok <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			prog <= next_prog;
			pin_ok <= next_pin_ok;
			done <= next_done;
		end
	end

	assign busy = (state != t_idle);
	assign inserting_wait = (state == t_prog) || (state == t_pin);
endmodule : bus_access_timer

/* File: verif/ext_bus_wait_monitor.sv */
/*
 * concurrent checks on the ports of the external bus wait controller.
 * assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/10ps
module ext_bus_wait_monitor
	import ext_bus_wait_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic access_req,
	input wire logic [1:0] access_kind,
	input wire logic access_word,
	input wire logic access_done,
	input wire logic ext_cycle_active,
	input wire logic access_byte_lane,
	input wire logic wide_bus,
	input wire logic bus_request_in_n,
	input wire logic bus_grant_n,
	input wire logic dma_burst_active
);
	// ---------------------------------------------------------------
	// bus release
	// ---------------------------------------------------------------
	default clocking mon_clk @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	grant_needs_req_a: assert property ($fell(bus_grant_n) |->
		!$past(bus_request_in_n) && !$past(bus_request_in_n, 2))
		else $error("grant without a standing request");
	grant_vs_cycle_a: assert property (!(ext_cycle_active &&
		!bus_grant_n)) else $error("grant during external cycle");
	dma_hold_a: assert property (dma_burst_active &&
		$past(dma_burst_active) && bus_grant_n |=> bus_grant_n)
		else $error("grant during dma burst");
	grant_release_a: assert property ($rose(bus_request_in_n) |->
		##[1:3] bus_grant_n) else $error("grant not withdrawn");
	// ---------------------------------------------------------------
	// cpu side accesses
	// ---------------------------------------------------------------
	done_pulse_a: assert property (access_done |=> !access_done)
		else $error("done longer than one cycle");
	done_cause_a: assert property (access_done |-> access_req)
		else $error("done without request");
	byte_lane_a: assert property ($rose(access_byte_lane) |->
		access_word && !wide_bus) else $error("second byte unexpected");
	onchip_ext_a: assert property (access_req && $past(access_req) &&
		$past(access_req, 2) && access_kind != kind_external |->
		!ext_cycle_active) else $error("internal access on the pins");
	// register port refuses new work while an answer is pending
	write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken with response pending");
	read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken with data pending");
endmodule : ext_bus_wait_monitor

bind ext_bus_wait_ctrl ext_bus_wait_monitor u_mon (
	.mclk(mclk),
	.reset_n(reset_n),
	.s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.access_req(access_req),
	.access_kind(access_kind),
	.access_word(access_word),
	.access_done(access_done),
	.ext_cycle_active(ext_cycle_active),
	.access_byte_lane(access_byte_lane),
	.wide_bus(wide_bus),
	.bus_request_in_n(bus_request_in_n),
	.bus_grant_n(bus_grant_n),
	.dma_burst_active(dma_burst_active)
);

/* File: verif/ext_party_model.sv */
/*
 * far side model: external memory wait logic and an external master.
 * assumes the bench sets pin_hold before each external cycle.
 */
`timescale 1ns/10ps
module ext_party_model (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ext_cycle_active,
	input wire logic [3:0] pin_hold,
	input wire logic want_bus,
	output logic wait_pin_n,
	output logic bus_request_in_n
);
	logic [3:0] cyc_cnt;
	logic [3:0] next_cyc_cnt;
	logic next_bus_request_in_n;

	// ---------------------------------------------------------------
	// wait pin and request
	// ---------------------------------------------------------------
	// counts states of the cycle; returns to zero after 15, so the pin can fall again in long cycles
	always_comb begin
		next_cyc_cnt = 4'h0;
		if (ext_cycle_active && cyc_cnt != 4'hF) begin
			next_cyc_cnt = cyc_cnt + 4'h1;
		end
		// master keeps asking until it is done with the bus
		next_bus_request_in_n = !want_bus;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cyc_cnt <= 4'h0;
			bus_request_in_n <= 1'b1;
		end else begin
			cyc_cnt <= next_cyc_cnt;
			bus_request_in_n <= next_bus_request_in_n;
		end
	end

	// low for a fixed span of states; pulled up outside cycles
	assign wait_pin_n = !(ext_cycle_active && cyc_cnt < pin_hold);
endmodule : ext_party_model

/* File: verif/external_bus_wait_state_control_tb.sv */
/*
 * self-checking bench for the external bus wait controller.
 * assumes the package constants and the far side model.
 */
`timescale 1ns/10ps
module external_bus_wait_state_control_tb;
	import ext_bus_wait_pkg::*;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [9:0] s_axi_awaddr = 10'h000;
	logic [9:0] s_axi_araddr = 10'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic access_req = 1'b0;
	logic [2:0] access_area = 3'h0;
	logic [1:0] access_kind = 2'h0;
	logic access_word = 1'b0;
	logic access_done, ext_cycle_active, access_byte_lane, wide_bus;
	logic wait_pin_n, bus_request_in_n, bus_grant_n;
	logic dma_burst_active = 1'b0;
	logic want_bus = 1'b0;
	logic [3:0] pin_hold = 4'h0;
	logic grant_seen, lane_seen, wide_seen;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	int off;

	// ---------------------------------------------------------------
	// clock, design, far side
	// ---------------------------------------------------------------
	always #2.5 mclk = ~mclk;

	ext_bus_wait_ctrl u_dut (.mclk(mclk), .reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .access_req(access_req),
		.access_area(access_area), .access_kind(access_kind),
		.access_word(access_word), .access_done(access_done),
		.ext_cycle_active(ext_cycle_active),
		.access_byte_lane(access_byte_lane), .wide_bus(wide_bus),
		.wait_pin_n(wait_pin_n), .bus_request_in_n(bus_request_in_n),
		.bus_grant_n(bus_grant_n), .dma_burst_active(dma_burst_active));

	ext_party_model u_far (.mclk(mclk), .reset_n(reset_n),
		.ext_cycle_active(ext_cycle_active), .pin_hold(pin_hold),
		.want_bus(want_bus), .wait_pin_n(wait_pin_n),
		.bus_request_in_n(bus_request_in_n));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task end_sim;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim

	task check(input string name, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// hang guard: whole run is a few hundred cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	task axi_wr(input logic [9:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [9:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	// one cpu access; ask raises a bus request two states into it
	task access(input logic [2:0] ar, input logic [1:0] k, input logic w,
		input logic [3:0] h, input logic ask, output int d);
		@(posedge mclk);
		pin_hold <= h;
		access_req <= 1'b1;
		access_area <= ar;
		access_kind <= k;
		access_word <= w;
		d = 0;
		grant_seen = 1'b0;
		lane_seen = 1'b0;
		wide_seen = 1'b0;
		while (d < 100) begin
			@(posedge mclk);
			d++;
			if (d == 2) want_bus <= ask;
			grant_seen = grant_seen | (bus_grant_n === 1'b0);
			lane_seen = lane_seen | (access_byte_lane === 1'b1);
			wide_seen = (wide_bus === 1'b1);
			if (access_done === 1'b1) break;
		end
		access_req <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : access

	task grant_try(input int n, output logic got);
		got = 1'b0;
		repeat (n) begin
			@(posedge mclk);
			got = got | (bus_grant_n === 1'b0);
		end
	endtask : grant_try

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_regs;
		logic [9:0] ra [3] = '{access_state_select_addr,
			wait_enable_per_area_addr, wait_count_control_addr};
		logic [15:0] rv [3] = '{16'h00FC, 16'hDF38, 16'h00F5};
		logic [7:0] rs [3] = '{access_state_select_rst,
			wait_enable_per_area_rst, wait_count_control_rst};
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 3; i++) begin
			axi_rd(ra[i], d, r);
			check("reg_reset", d[7:0], rs[i]);
			axi_wr(ra[i], {16'h0, rv[i]}, r);
			check("wr_resp", r, axi_okay);
			axi_rd(ra[i], d, r);
			check("reg_back", d[15:0], rv[i]);
		end
		axi_rd(10'h008, d, r);
		check("rd_unmapped", r, axi_slverr);
		axi_wr(10'h008, 32'h0000_00FF, r);
		check("wr_unmapped", r, axi_slverr);
	endtask : t_regs

	// example map: pin holds cover base, programmed and pin waits
	task t_areas;
		logic [3:0] hold [8] = '{0, 0, 0, 0, 0, 3, 4, 4};
		int exp [8] = '{2, 2, 3, 4, 4, 5, 6, 6};
		int d;
		access(3'h0, kind_external, 1'b0, 4'h0, 1'b0, d);
		off = d - 2;
		for (int i = 0; i < 8; i++) begin
			access(i[2:0], kind_external, 1'b0, hold[i], 1'b0, d);
			check("area_states", d - off, exp[i]);
			check("area_width", wide_seen, 8'hDF >> i & 1);
		end
		access(3'h1, kind_external, 1'b0, 4'hF, 1'b0, d);
		check("two_state_pin", d - off, 2);
	endtask : t_areas

	task t_fixed;
		int d;
		access(3'h6, kind_onchip_ram, 1'b0, 4'h6, 1'b0, d);
		check("ram_states", d - off, 2);
		check("ram_wide", wide_seen, 1);
		access(3'h0, kind_internal_io, 1'b0, 4'h0, 1'b0, d);
		check("io_states", d - off, 3);
	endtask : t_fixed

	task t_grant;
		logic [2:0] m [3] = '{3'h3, 3'h5, 3'h1};
		logic g [3] = '{1'b1, 1'b0, 1'b1};
		logic got;
		logic [1:0] r;
		for (int i = 0; i < 3; i++) begin
			axi_wr(mode_control_addr, {29'h0, m[i]}, r);
			want_bus <= 1'b1;
			grant_try(12, got);
			check("grant_mode", got, g[i]);
			want_bus <= 1'b0;
			repeat (4) @(posedge mclk);
			check("grant_off", bus_grant_n, 1);
		end
		dma_burst_active <= 1'b1;
		want_bus <= 1'b1;
		grant_try(30, got);
		check("grant_dma", got, 0);
		dma_burst_active <= 1'b0;
		grant_try(12, got);
		check("grant_after_dma", got, 1);
		want_bus <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask : t_grant

	// word over the byte-wide area with a request arriving mid-way
	task t_word;
		int d;
		logic got;
		access(3'h5, kind_external, 1'b1, 4'h0, 1'b1, d);
		check("word_states", d - off, 8);
		check("word_lane", lane_seen, 1);
		check("word_no_grant", grant_seen, 0);
		grant_try(10, got);
		check("word_grant", got, 1);
		want_bus <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask : t_word

	initial begin
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_regs();
		t_areas();
		t_fixed();
		t_grant();
		t_word();
		end_sim();
	end
endmodule : external_bus_wait_state_control_tb
